// >>> rtl/tesel_pkg.sv
package tesel_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
   localparam int GO_BIT = 0;
   localparam int START_LSB = 8;
   localparam int RSVD_BIT = 11;
   localparam int STOP_LSB = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_7701;
   localparam int ST_EN_BIT = 0;
   localparam int ST_PIN_BIT = 1;
   localparam int ST_TRG_BIT = 2;

   localparam logic [2:0] START_ALWAYS = 3'h0;
   localparam logic [2:0] START_LOWER_ON = 3'h1;
   localparam logic [2:0] START_TRG_HIGH = 3'h2;
   localparam logic [2:0] START_TRG_PIN_HIGH = 3'h3;
   localparam logic [2:0] START_PIN_RISE = 3'h4;
   localparam logic [2:0] START_PIN_RISE_TRG = 3'h5;
   localparam logic [2:0] START_TRG_RISE = 3'h6;

   localparam logic [2:0] STOP_NEVER = 3'h0;
   localparam logic [2:0] STOP_LOWER_OFF = 3'h1;
   localparam logic [2:0] STOP_CMP = 3'h2;
   localparam logic [2:0] STOP_CMP_TRG_LOW = 3'h3;
   localparam logic [2:0] STOP_PIN_EDGE = 3'h4;
   localparam logic [2:0] STOP_PIN_EDGE_TRG = 3'h5;
   localparam logic [2:0] STOP_TRG_FALL = 3'h6;

   typedef enum logic [1:0] {
      TESEL_OFF = 2'b00,
      TESEL_WAIT = 2'b01,
      TESEL_RUN = 2'b10
   } tesel_state_e;
endpackage : tesel_pkg

// >>> rtl/tesel_timer_enable_disable_select.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tesel_timer_enable_disable_select (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tesel_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pinIn,
   input wire logic triggerIn,
   input wire logic lowerEnabled,
   input wire logic compareEvent,
   output logic timerEnabled,
   output logic startPulse,
   output logic stopPulse
);
   import tesel_pkg::*;

   function automatic logic rose(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rose

   function automatic logic fell(input logic cur, input logic prev);
      return ~cur & prev;
   endfunction : fell

   logic [31:0] ctrl;
   logic pinMeta, pinSync, pinPrev;
   logic trgMeta, trgSync, trgPrev;
   logic lowerPrev;
   logic armed;
   logic [2:0] startSel;
   logic [2:0] stopSel;
   logic pinRise, pinEdge, trgRise, trgFall, lowerRise, lowerFall;
   logic startHit, stopHit;
   logic busSetup, busWrite, addrOk;
   tesel_state_e state, next_state;

   assign armed = ctrl[GO_BIT];
   assign startSel = ctrl[START_LSB +: 3];
   assign stopSel = ctrl[STOP_LSB +: 3];
   assign busSetup = psel & ~penable;
   assign busWrite = psel & penable & pready & pwrite;
   assign addrOk = (paddr == CTRL_OFS) || (paddr == STAT_OFS);

   // Pins are asynchronous; the first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         trgMeta <= 1'b0;
         trgSync <= 1'b0;
      end else begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
         trgMeta <= triggerIn;
         trgSync <= trgMeta;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinPrev <= 1'b0;
         trgPrev <= 1'b0;
         lowerPrev <= 1'b0;
      end else begin
         pinPrev <= pinSync;
         trgPrev <= trgSync;
         lowerPrev <= lowerEnabled;
      end
   end

   assign pinRise = rose(pinSync, pinPrev);
   assign pinEdge = pinSync ^ pinPrev;
   assign trgRise = rose(trgSync, trgPrev);
   assign trgFall = fell(trgSync, trgPrev);
   assign lowerRise = rose(lowerEnabled, lowerPrev);
   assign lowerFall = fell(lowerEnabled, lowerPrev);

   always_comb begin
      case (startSel)
         START_ALWAYS: startHit = 1'b1;
         START_LOWER_ON: startHit = lowerRise;
         START_TRG_HIGH: startHit = trgSync;
         START_TRG_PIN_HIGH: startHit = trgSync & pinSync;
         START_PIN_RISE: startHit = pinRise;
         START_PIN_RISE_TRG: startHit = pinRise & trgSync;
         START_TRG_RISE: startHit = trgRise;
         default: startHit = 1'b0;
      endcase
   end

   // Reserved code 111 is treated as never stopping
   always_comb begin
      case (stopSel)
         STOP_NEVER: stopHit = 1'b0;
         STOP_LOWER_OFF: stopHit = lowerFall;
         STOP_CMP: stopHit = compareEvent;
         STOP_CMP_TRG_LOW: stopHit = compareEvent & ~trgSync;
         STOP_PIN_EDGE: stopHit = pinEdge;
         STOP_PIN_EDGE_TRG: stopHit = pinEdge & trgSync;
         STOP_TRG_FALL: stopHit = trgFall;
         default: stopHit = 1'b0;
      endcase
   end

   // A running timer looks only at GO and stop events, so a stop wins over a start only while running; a waiting timer ignores stops
   always_comb begin
      next_state = state;
      case (state)
         TESEL_OFF: begin
            if (armed) begin
               next_state = startHit ? TESEL_RUN : TESEL_WAIT;
            end
         end
         TESEL_WAIT: begin
            if (!armed) begin
               next_state = TESEL_OFF;
            end else if (startHit) begin
               next_state = TESEL_RUN;
            end
         end
         TESEL_RUN: begin
            if (!armed) begin
               next_state = TESEL_OFF;
            end else if (stopHit) begin
               next_state = TESEL_WAIT;
            end
         end
         default: next_state = TESEL_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= TESEL_OFF;
         timerEnabled <= 1'b0;
         startPulse <= 1'b0;
         stopPulse <= 1'b0;
      end else begin
         state <= next_state;
         timerEnabled <= (next_state == TESEL_RUN);
         startPulse <= (state != TESEL_RUN) && (next_state == TESEL_RUN);
         stopPulse <= (state == TESEL_RUN) && (next_state == TESEL_WAIT);
      end
   end

   // Zero-wait slave: pready is raised for the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= busSetup;
         pslverr <= busSetup & ~addrOk;
         prdata <= 32'h0000_0000;
         if (busSetup && !pwrite) begin
            if (paddr == CTRL_OFS) begin
               prdata <= ctrl;
            end else if (paddr == STAT_OFS) begin
               prdata[ST_EN_BIT] <= timerEnabled;
               prdata[ST_PIN_BIT] <= pinSync;
               prdata[ST_TRG_BIT] <= trgSync;
            end
         end
      end
   end

   // Mask keeps bit 11 and every unused bit at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RST;
      end else if (busWrite && paddr == CTRL_OFS) begin
         ctrl <= pwdata & CTRL_WMASK;
      end
   end

   bit11_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      psel && penable && pready && !pwrite && paddr == CTRL_OFS |-> !prdata[RSVD_BIT])
      else $error("reserved bit 11 read nonzero");

   never_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      timerEnabled && stopSel == STOP_NEVER && armed && $stable(ctrl)
      |=> timerEnabled)
      else $error("timer stopped with stop code 000");

   lower_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_LOWER_OFF && $fell(lowerEnabled)
      |=> !timerEnabled && stopPulse)
      else $error("no stop on lower timer disable");

   cmp_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && stopSel == STOP_CMP && compareEvent |=> !timerEnabled)
      else $error("no stop on compare");

   cmp_trig_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_CMP_TRG_LOW && trgSync
      |=> timerEnabled)
      else $error("compare stopped timer while trigger high");

   pin_edge_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && stopSel == STOP_PIN_EDGE && pinSync != $past(pinSync)
      |=> !timerEnabled)
      else $error("no stop on pin edge");

   pin_trig_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_PIN_EDGE_TRG && !trgSync
      |=> timerEnabled)
      else $error("pin edge stopped timer with trigger low");

   trig_fall_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_TRG_FALL && $fell(trgSync)
      |=> !timerEnabled && stopPulse)
      else $error("no stop on trigger fall");

   always_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state != TESEL_RUN && armed && startSel == START_ALWAYS |=> timerEnabled)
      else $error("start code 000 did not start");

   lower_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_LOWER_ON
      && !timerEnabled ##1 timerEnabled |-> $past(lowerEnabled, 2) == 1'b0)
      else $error("start without lower timer rising");

   trig_high_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_TRG_HIGH
      |=> timerEnabled == $past(trgSync))
      else $error("trigger high start mismatch");

   trig_pin_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_TRG_PIN_HIGH
      |=> timerEnabled == $past(trgSync & pinSync))
      else $error("trigger and pin start mismatch");

   pin_rise_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_PIN_RISE
      |=> timerEnabled == $past(pinSync && !pinPrev))
      else $error("pin rise start mismatch");

   pin_rise_trg_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_PIN_RISE_TRG
      |=> timerEnabled == $past(pinRise && trgSync))
      else $error("pin rise with trigger start mismatch");

   trig_rise_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT && armed && startSel == START_TRG_RISE
      |=> timerEnabled == $past(trgSync && !trgPrev))
      else $error("trigger rise start mismatch");

   pin_sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pinIn) ##1 pinIn ##1 pinIn |-> pinRise ##1 !pinRise)
      else $error("pin edge not two stages late");

   cmp_low_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_CMP_TRG_LOW && compareEvent && !trgSync
      |=> !timerEnabled && stopPulse)
      else $error("no stop on compare with trigger low");

   pin_trg_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && armed && stopSel == STOP_PIN_EDGE_TRG && pinEdge && trgSync
      |=> !timerEnabled && stopPulse)
      else $error("no stop on pin edge with trigger high");

   start_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      startPulse |-> timerEnabled && !$past(timerEnabled))
      else $error("start pulse without enable rising");

   rsvd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl[RSVD_BIT])
      else $error("reserved bit 11 stored nonzero");

   start_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_WAIT ##1 startPulse);
   stop_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      timerEnabled ##1 stopPulse);
   restart_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      stopPulse ##[1:20] startPulse);
   bad_addr_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      pready && pslverr);
   lower_stop_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
      state == TESEL_RUN && stopSel == STOP_LOWER_OFF ##1 stopPulse);
endmodule : tesel_timer_enable_disable_select

// >>> verif/test_timer_enable_disable_select.sv
`timescale 1ns/1ps
module test_timer_enable_disable_select;
   import tesel_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic pinIn, triggerIn, lowerEnabled, compareEvent;
   logic timerEnabled, startPulse, stopPulse;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, data;
   logic [32:0] expq[$];
   logic [32:0] e;
   // Expected pulses, {start, stop}, in order of appearance
   logic [1:0] pulseq[$];
   logic [1:0] pe;
   int mismatches, comparisons, seed;
   // Input steps {pin, trigger, lower, compare}; A steps must not move the timer
   logic [3:0] startA[7] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h4, 4'h4, 4'h8};
   logic [3:0] startB[7] = '{4'h0, 4'h2, 4'hC, 4'hC, 4'hC, 4'hC, 4'h4};
   logic [6:0] startExpA = 7'h01;
   logic [1:0] stopInit[7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1};
   logic [3:0] stopA[7] = '{4'hF, 4'h3, 4'hE, 4'h7, 4'h7, 4'hE, 4'hF};
   logic [3:0] stopB[7] = '{4'h1, 4'h0, 4'hF, 4'h3, 4'hE, 4'h6, 4'hA};
   logic [6:0] stopExpB = 7'h01;

   tesel_timer_enable_disable_select i_dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pinIn(pinIn), .triggerIn(triggerIn),
      .lowerEnabled(lowerEnabled), .compareEvent(compareEvent),
      .timerEnabled(timerEnabled), .startPulse(startPulse), .stopPulse(stopPulse)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic conclude;
      repeat (2) @(posedge clk);
      if (expq.size() != 0 || pulseq.size() != 0) mismatches++;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   // Expectation is queued before the transfer; the monitor pairs it at pready
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [32:0] ex);
      int k;
      expq.push_back(ex);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic stat(input logic en);
      xfer(1'b0, STAT_OFS, 32'h0, {1'b0, (32'(en) << ST_EN_BIT) | (32'(pinIn) << ST_PIN_BIT)
           | (32'(triggerIn) << ST_TRG_BIT)});
   endtask : stat

   // Long settle covers the two-flop synchronisers plus the edge register
   task automatic drive(input logic [3:0] v);
      @(posedge clk);
      pinIn <= v[3];
      triggerIn <= v[2];
      lowerEnabled <= v[1];
      repeat (5) @(posedge clk);
      compareEvent <= v[0];
      @(posedge clk);
      compareEvent <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : drive

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (expq.size() == 0) begin
            mismatches++;
            $display("CHECK FAILED apb queue expected entry seen none");
         end else begin
            e = expq.pop_front();
            comparisons++;
            if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) begin
               mismatches++;
               $display("CHECK FAILED apb %h expected %h seen %h", paddr, e, {pslverr, prdata});
            end
         end
      end
   end

   always @(posedge clk) begin
      if (startPulse === 1'b1 || stopPulse === 1'b1) begin
         if (pulseq.size() == 0) begin
            mismatches++;
            $display("CHECK FAILED pulse expected none seen %b", {startPulse, stopPulse});
         end else begin
            pe = pulseq.pop_front();
            comparisons++;
            if ({startPulse, stopPulse} !== pe) begin
               mismatches++;
               $display("CHECK FAILED pulse expected %b seen %b", pe, {startPulse, stopPulse});
            end
         end
      end
   end

   initial begin
      seed = 11725;
      mismatches = 0;
      comparisons = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      pinIn = 1'b0;
      triggerIn = 1'b0;
      lowerEnabled = 1'b0;
      compareEvent = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(1'b0, CTRL_OFS, 32'h0, {1'b0, CTRL_RST});
      stat(1'b0);
      xfer(1'b1, CTRL_OFS, 32'hFFFF_EFFF, 33'h0);
      xfer(1'b0, CTRL_OFS, 32'h0, {1'b0, CTRL_WMASK & 32'hFFFF_EFFF});
      data = $random(seed) & 32'hFFFF_BFFE;
      xfer(1'b1, CTRL_OFS, data, 33'h0);
      xfer(1'b0, CTRL_OFS, 32'h0, {1'b0, data & CTRL_WMASK});
      xfer(1'b1, 12'h008, data, {1'b1, 32'h0});
      xfer(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
      $display("Register test done");
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, CTRL_OFS, 32'h0, 33'h0);
         drive(4'h0);
         pulseq.push_back(2'b10);
         xfer(1'b1, CTRL_OFS, (32'(i) << START_LSB) | 32'h1, 33'h0);
         drive(startA[i]);
         stat(startExpA[i]);
         drive(startB[i]);
         stat(1'b1);
      end
      $display("Start condition test done");
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, CTRL_OFS, 32'h0, 33'h0);
         drive({stopInit[i], 2'b00});
         pulseq.push_back(2'b10);
         xfer(1'b1, CTRL_OFS, (32'(i) << STOP_LSB) | (32'h1 << START_LSB) | 32'h1, 33'h0);
         drive({stopInit[i], 2'b10});
         stat(1'b1);
         drive(stopA[i]);
         stat(1'b1);
         if (!stopExpB[i]) pulseq.push_back(2'b01);
         drive(stopB[i]);
         stat(stopExpB[i]);
      end
      $display("Stop condition test done");
      conclude();
   end
endmodule : test_timer_enable_disable_select
